// file: verilog/adsc_pkg.sv
`default_nettype none
package adsc_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_DRATE = 8'h04;
	localparam logic [7:0] ADDR_REFCTL = 8'h05;
	localparam logic [7:0] ADDR_SYSCTL = 8'h09;
	localparam logic [7:0] ADDR_OFC_LO = 8'h0a;
	localparam logic [7:0] ADDR_OFC_HI = 8'h0b;
	localparam logic [7:0] ADDR_FSC_LO = 8'h0c;
	localparam logic [7:0] ADDR_FSC_HI = 8'h0d;
	localparam logic [7:0] ADDR_GPIO_VAL = 8'h10;
	localparam logic [7:0] ADDR_GPIO_CFG = 8'h11;
	localparam logic [7:0] ADDR_DATA_LO = 8'h12;
	localparam logic [7:0] ADDR_DATA_HI = 8'h13;
	localparam logic [7:0] ADDR_CMD = 8'h14;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_POR = 7;
	localparam int BIT_RDY_N = 6;
	localparam int BIT_LOW_REF = 0;
	localparam int BIT_MODE = 5;
	localparam int BIT_EXT_CLK = 6;
	localparam int BIT_REF_MON_EN = 7;
	localparam int POS_MON_SEL = 5;
	localparam int POS_CAL_AVG = 3;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DRATE = 8'h14;
	localparam logic [7:0] RST_REFCTL = 8'h00;
	localparam logic [7:0] RST_SYSCTL = 8'h10;
	localparam logic [7:0] RST_GPIO_VAL = 8'h00;
	localparam logic [7:0] RST_GPIO_CFG = 8'h00;
	localparam logic [15:0] RST_OFC = 16'h0000;
	localparam logic [15:0] RST_FSC = 16'h4000;
	// ------------------------------------------------------------
	// Calibration constants
	// ------------------------------------------------------------
	localparam logic [2:0] MON_SELF_OFFSET = 3'h1;
	localparam logic [29:0] GAIN_TARGET = 30'h1fffc000;
	localparam int GAIN_SHIFT = 14;
	localparam logic [15:0] POS_LIMIT = 16'h7fff;
	localparam logic [15:0] NEG_LIMIT = 16'h8000;
	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [15:0] CONV_CYCLES = 16'h0040;
	localparam logic [7:0] READY_CYCLES = 8'h10;
	// ------------------------------------------------------------
	// Commands written to the command register
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_RESUME = 8'h02;
	localparam logic [7:0] CMD_SLEEP = 8'h04;
	localparam logic [7:0] CMD_RESET = 8'h06;
	localparam logic [7:0] CMD_START = 8'h08;
	localparam logic [7:0] CMD_STOP = 8'h0a;
	localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'h16;
	localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'h17;
	localparam logic [7:0] CMD_SELF_OFFSET_CAL = 8'h19;

	typedef enum {ST_STBY, ST_CONV, ST_CAL, ST_PDOWN} adsc_state_type;
	typedef enum logic [1:0] {CAL_SELF_OFS, CAL_SYS_OFS, CAL_SYS_GAIN} adsc_cal_type;

	typedef struct packed {
		logic power_on_flag;
		logic ready_n;
		logic [4:0] reserved;
		logic low_ref_flag;
	} adsc_status_type;
endpackage
`default_nettype wire

// file: verilog/adsc_core.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_core
	import adsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic reset_pin_n,
	input wire logic start_pin,
	input wire logic ref_low_in,
	input wire logic [15:0] filter_data,
	input wire logic [3:0] gpio_in,
	output logic [3:0] gpio_out,
	output logic [3:0] gpio_oe,
	output logic [3:0] gpio_func,
	output logic conversion_done_n,
	output logic [15:0] conv_data,
	output logic [2:0] monitor_select,
	output logic ext_clk_select,
	output logic converting,
	output logic powered_down
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [6:0] sync1_r, sync2_r;
	logic rst_pin_s, start_s, ref_low_s;
	logic [3:0] gpio_s;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Trigger bit idles low so release of reset shows no false edge
			sync1_r <= 7'h01;
			sync2_r <= 7'h01;
		end else begin
			sync1_r <= {gpio_in, ref_low_in, start_pin, reset_pin_n};
			sync2_r <= sync1_r;
		end
	end
	assign rst_pin_s = sync2_r[0];
	assign start_s = sync2_r[1];
	assign ref_low_s = sync2_r[2];
	assign gpio_s = sync2_r[6:3];

	// ------------------------------------------------------------
	// Control and register state
	// ------------------------------------------------------------
	adsc_state_type state_r, state_nxt;
	adsc_cal_type cal_kind_r, cal_kind_nxt;
	adsc_status_type status_r, status_nxt;
	logic [15:0] timer_r, timer_nxt;
	logic [7:0] rdy_cnt_r, rdy_cnt_nxt;
	logic [7:0] drate_r, drate_nxt, refctl_r, refctl_nxt, sysctl_r, sysctl_nxt;
	logic [7:0] gval_r, gval_nxt, gcfg_r, gcfg_nxt, rdata_r, rdata_nxt;
	logic [15:0] ofc_r, ofc_nxt, fsc_r, fsc_nxt, data_r, data_nxt;
	logic [19:0] acc_r, acc_nxt;
	logic [4:0] cal_cnt_r, cal_cnt_nxt;
	logic done_n_r, done_n_nxt, fault_r, fault_nxt, stop_pend_r, stop_pend_nxt;
	logic start_d_r;

	// ------------------------------------------------------------
	// Calibration datapath
	// ------------------------------------------------------------
	logic signed [16:0] diff;
	logic signed [33:0] prod;
	logic signed [33:0] scaled;
	logic [15:0] cal_out;
	logic [4:0] avg_n;
	logic [2:0] avg_sh;
	logic signed [19:0] acc_sum;
	logic [15:0] avg_val;
	logic signed [16:0] gain_div;
	logic [29:0] gain_q;
	logic [15:0] gain_new;
	logic [3:0] gpio_rd;

	always_comb begin
		diff = $signed({filter_data[15], filter_data}) - $signed({ofc_r[15], ofc_r});
		prod = diff * $signed({1'b0, fsc_r});
		scaled = prod >>> GAIN_SHIFT;
		if (scaled > $signed({18'h00000, POS_LIMIT})) begin
			cal_out = POS_LIMIT;
		end else if (scaled < -$signed({18'h00000, NEG_LIMIT})) begin
			cal_out = NEG_LIMIT;
		end else begin
			cal_out = scaled[15:0];
		end
	end

	always_comb begin
		case (sysctl_r[POS_CAL_AVG +: 2])
			2'h0: begin
				avg_n = 5'h01;
				avg_sh = 3'h0;
			end
			2'h1: begin
				avg_n = 5'h04;
				avg_sh = 3'h2;
			end
			2'h2: begin
				avg_n = 5'h08;
				avg_sh = 3'h3;
			end
			default: begin
				avg_n = 5'h10;
				avg_sh = 3'h4;
			end
		endcase
		acc_sum = $signed(acc_r) + $signed({{4{filter_data[15]}}, filter_data});
		avg_val = 16'(acc_sum >>> avg_sh);
		gain_div = $signed({avg_val[15], avg_val}) - $signed({ofc_r[15], ofc_r});
		// Non-positive span would divide by zero, so the old word is kept
		gain_q = (gain_div > 0) ? GAIN_TARGET / 30'(gain_div) : {14'h0000, fsc_r};
		gain_new = (gain_q[29:16] != 14'h0000) ? 16'hffff : gain_q[15:0];
	end

	// ------------------------------------------------------------
	// GPIO
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gpio
			// Direction bit high selects input
			assign gpio_oe[gi] = gcfg_r[gi] & ~gval_r[4 + gi];
			assign gpio_out[gi] = gval_r[gi];
			assign gpio_rd[gi] = gval_r[4 + gi] ? gpio_s[gi] : gval_r[gi];
		end
	endgenerate
	assign gpio_func = gcfg_r[3:0];

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic wr_cmd, soft_rst, start_ev, cal_ev, conv_end;

	always_comb begin
		state_nxt = state_r;
		cal_kind_nxt = cal_kind_r;
		status_nxt = status_r;
		timer_nxt = timer_r;
		rdy_cnt_nxt = rdy_cnt_r;
		drate_nxt = drate_r;
		refctl_nxt = refctl_r;
		sysctl_nxt = sysctl_r;
		gval_nxt = gval_r;
		gcfg_nxt = gcfg_r;
		ofc_nxt = ofc_r;
		fsc_nxt = fsc_r;
		data_nxt = data_r;
		acc_nxt = acc_r;
		cal_cnt_nxt = cal_cnt_r;
		done_n_nxt = done_n_r;
		fault_nxt = fault_r;
		stop_pend_nxt = stop_pend_r;
		rdata_nxt = 8'h00;

		wr_cmd = reg_wr && reg_addr == ADDR_CMD;
		soft_rst = !rst_pin_s || (wr_cmd && reg_wdata == CMD_RESET && state_r != ST_PDOWN);
		start_ev = (start_s && !start_d_r) || (wr_cmd && reg_wdata == CMD_START);
		cal_ev = wr_cmd && (reg_wdata == CMD_SELF_OFFSET_CAL ||
			reg_wdata == CMD_SYS_OFFSET_CAL || reg_wdata == CMD_SYS_GAIN_CAL);
		conv_end = timer_r == 16'h0001;

		// Ready flag counts down while the map is being rebuilt
		if (rdy_cnt_r != 8'h00) begin
			rdy_cnt_nxt = rdy_cnt_r - 8'h01;
		end
		status_nxt.ready_n = rdy_cnt_r != 8'h00;

		// Register reads, data one cycle later
		if (reg_rd) begin
			case (reg_addr)
				ADDR_STATUS: rdata_nxt = status_r;
				ADDR_DRATE: rdata_nxt = drate_r;
				ADDR_REFCTL: rdata_nxt = refctl_r;
				ADDR_SYSCTL: rdata_nxt = sysctl_r;
				ADDR_OFC_LO: rdata_nxt = ofc_r[7:0];
				ADDR_OFC_HI: rdata_nxt = ofc_r[15:8];
				ADDR_FSC_LO: rdata_nxt = fsc_r[7:0];
				ADDR_FSC_HI: rdata_nxt = fsc_r[15:8];
				ADDR_GPIO_VAL: rdata_nxt = {gval_r[7:4], gpio_rd};
				ADDR_GPIO_CFG: rdata_nxt = gcfg_r;
				ADDR_DATA_LO: rdata_nxt = data_r[7:0];
				ADDR_DATA_HI: rdata_nxt = data_r[15:8];
				default: rdata_nxt = 8'h00;
			endcase
		end

		// Register writes; power-down ignores them until resume
		if (reg_wr && state_r != ST_PDOWN) begin
			case (reg_addr)
				ADDR_STATUS: begin
					if (!reg_wdata[BIT_POR]) begin
						status_nxt.power_on_flag = 1'b0;
					end
				end
				ADDR_DRATE: drate_nxt = reg_wdata;
				ADDR_REFCTL: refctl_nxt = reg_wdata;
				ADDR_SYSCTL: sysctl_nxt = reg_wdata;
				ADDR_OFC_LO: ofc_nxt[7:0] = reg_wdata;
				ADDR_OFC_HI: ofc_nxt[15:8] = reg_wdata;
				ADDR_FSC_LO: fsc_nxt[7:0] = reg_wdata;
				ADDR_FSC_HI: fsc_nxt[15:8] = reg_wdata;
				ADDR_GPIO_VAL: gval_nxt = reg_wdata;
				ADDR_GPIO_CFG: gcfg_nxt = {4'h0, reg_wdata[3:0]};
				default: ;
			endcase
		end

		// Fault seen in any cycle of the conversion but the last is kept
		if (refctl_r[BIT_REF_MON_EN] && ref_low_s && state_r != ST_STBY && state_r != ST_PDOWN) begin
			fault_nxt = 1'b1;
		end
		if (timer_r != 16'h0000) begin
			timer_nxt = timer_r - 16'h0001;
		end
		if (wr_cmd && reg_wdata == CMD_STOP) begin
			stop_pend_nxt = 1'b1;
		end

		case (state_r)
			ST_STBY: begin
				if (start_ev) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (conv_end) begin
					data_nxt = cal_out;
					done_n_nxt = 1'b0;
					status_nxt.low_ref_flag = fault_r;
					fault_nxt = 1'b0;
					timer_nxt = CONV_CYCLES;
					// Single-shot, a pending stop or a low start pin ends the run after the ongoing conversion
					if (drate_r[BIT_MODE] || stop_pend_r || !start_s) begin
						state_nxt = ST_STBY;
						timer_nxt = 16'h0000;
						stop_pend_nxt = 1'b0;
					end else begin
						done_n_nxt = 1'b0;
					end
				end else if (timer_r == CONV_CYCLES - 16'h0004) begin
					done_n_nxt = 1'b1;
				end
				if (cal_ev) begin
					state_nxt = ST_CAL;
					cal_kind_nxt = (reg_wdata == CMD_SELF_OFFSET_CAL) ? CAL_SELF_OFS :
						(reg_wdata == CMD_SYS_OFFSET_CAL) ? CAL_SYS_OFS : CAL_SYS_GAIN;
					cal_cnt_nxt = 5'h00;
					acc_nxt = 20'h00000;
					timer_nxt = CONV_CYCLES;
					done_n_nxt = 1'b1;
				end
			end
			ST_CAL: begin
				if (conv_end) begin
					acc_nxt = acc_sum;
					cal_cnt_nxt = cal_cnt_r + 5'h01;
					timer_nxt = CONV_CYCLES;
					if (cal_cnt_r + 5'h01 == avg_n) begin
						if (cal_kind_r == CAL_SYS_GAIN) begin
							fsc_nxt = gain_new;
						end else begin
							ofc_nxt = avg_val;
						end
						state_nxt = ST_CONV;
						fault_nxt = 1'b0;
					end
				end
			end
			ST_PDOWN: begin
				if (wr_cmd && reg_wdata == CMD_RESUME) begin
					state_nxt = ST_STBY;
				end
			end
			default: state_nxt = ST_STBY;
		endcase

		// Restart beats the state machine outside power-down; a cal command in standby, sleep and reset still win over it
		if (start_ev && state_r != ST_PDOWN) begin
			state_nxt = ST_CONV;
			timer_nxt = CONV_CYCLES;
			fault_nxt = 1'b0;
			done_n_nxt = 1'b1;
			stop_pend_nxt = 1'b0;
		end
		if (state_r == ST_STBY && cal_ev) begin
			state_nxt = ST_STBY;
		end
		if (wr_cmd && reg_wdata == CMD_SLEEP && state_r != ST_PDOWN) begin
			state_nxt = ST_PDOWN;
			timer_nxt = 16'h0000;
			stop_pend_nxt = 1'b0;
		end

		if (soft_rst) begin
			state_nxt = ST_STBY;
			drate_nxt = RST_DRATE;
			refctl_nxt = RST_REFCTL;
			sysctl_nxt = RST_SYSCTL;
			gval_nxt = RST_GPIO_VAL;
			gcfg_nxt = RST_GPIO_CFG;
			ofc_nxt = RST_OFC;
			fsc_nxt = RST_FSC;
			timer_nxt = 16'h0000;
			done_n_nxt = 1'b1;
			fault_nxt = 1'b0;
			stop_pend_nxt = 1'b0;
			rdy_cnt_nxt = READY_CYCLES;
			status_nxt.ready_n = 1'b1;
			status_nxt.low_ref_flag = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_STBY;
			cal_kind_r <= CAL_SELF_OFS;
			status_r <= '{power_on_flag: 1'b1, ready_n: 1'b1, reserved: 5'h00,
				low_ref_flag: 1'b0};
			timer_r <= 16'h0000;
			rdy_cnt_r <= READY_CYCLES;
			drate_r <= RST_DRATE;
			refctl_r <= RST_REFCTL;
			sysctl_r <= RST_SYSCTL;
			gval_r <= RST_GPIO_VAL;
			gcfg_r <= RST_GPIO_CFG;
			ofc_r <= RST_OFC;
			fsc_r <= RST_FSC;
			data_r <= 16'h0000;
			acc_r <= 20'h00000;
			cal_cnt_r <= 5'h00;
			done_n_r <= 1'b1;
			fault_r <= 1'b0;
			stop_pend_r <= 1'b0;
			rdata_r <= 8'h00;
			start_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cal_kind_r <= cal_kind_nxt;
			status_r <= status_nxt;
			timer_r <= timer_nxt;
			rdy_cnt_r <= rdy_cnt_nxt;
			drate_r <= drate_nxt;
			refctl_r <= refctl_nxt;
			sysctl_r <= sysctl_nxt;
			gval_r <= gval_nxt;
			gcfg_r <= gcfg_nxt;
			ofc_r <= ofc_nxt;
			fsc_r <= fsc_nxt;
			data_r <= data_nxt;
			acc_r <= acc_nxt;
			cal_cnt_r <= cal_cnt_nxt;
			done_n_r <= done_n_nxt;
			fault_r <= fault_nxt;
			stop_pend_r <= stop_pend_nxt;
			rdata_r <= rdata_nxt;
			start_d_r <= start_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign conversion_done_n = done_n_r;
	assign conv_data = data_r;
	assign monitor_select = (state_r == ST_CAL && cal_kind_r == CAL_SELF_OFS) ?
		MON_SELF_OFFSET : sysctl_r[POS_MON_SEL +: 3];
	assign ext_clk_select = drate_r[BIT_EXT_CLK];
	assign converting = state_r == ST_CONV || state_r == ST_CAL;
	assign powered_down = state_r == ST_PDOWN;
endmodule // adsc_core
`default_nettype wire

// file: sim/adsc_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_core_asserts
	import adsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reset_pin_n,
	input wire logic [3:0] gpio_oe,
	input wire logic [3:0] gpio_func,
	input wire logic conversion_done_n,
	input wire logic [15:0] conv_data,
	input wire logic [2:0] monitor_select,
	input wire logic ext_clk_select,
	input wire logic converting,
	input wire logic powered_down
);
	// ------
	// Helpers
	// ------
	// Pin reset reaches the core late, so recent pin lows mask mode checks
	logic [3:0] pin_hist_r;
	logic quiet;
	logic cmd_wr;
	logic cal_wr;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_hist_r <= 4'hf;
		end else begin
			pin_hist_r <= {pin_hist_r[2:0], reset_pin_n};
		end
	end
	assign quiet = &pin_hist_r && reset_pin_n;
	assign cmd_wr = reg_wr && reg_addr == ADDR_CMD;
	assign cal_wr = cmd_wr && (reg_wdata == CMD_SELF_OFFSET_CAL ||
		reg_wdata == CMD_SYS_OFFSET_CAL || reg_wdata == CMD_SYS_GAIN_CAL);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_oe_func;
		(gpio_oe & ~gpio_func) == 4'h0;
	endproperty
	a_oe_func: assert property (p_oe_func)
		else $error("pin driven while not gpio");
	property p_sleep;
		cmd_wr && reg_wdata == CMD_SLEEP && quiet |=> powered_down && !converting;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep did not stop at once");
	property p_start;
		cmd_wr && reg_wdata == CMD_START && !powered_down && quiet |=> converting;
	endproperty
	a_start: assert property (p_start)
		else $error("start did not begin conversion");
	property p_done;
		$fell(conversion_done_n) |-> $past(converting);
	endproperty
	a_done: assert property (p_done)
		else $error("done fell without conversion");
	property p_data;
		$changed(conv_data) && $past(converting) |-> $fell(conversion_done_n);
	endproperty
	a_data: assert property (p_data)
		else $error("result changed off done edge");
	property p_clk;
		$rose(rst_n) |-> !ext_clk_select;
	endproperty
	a_clk: assert property (p_clk)
		else $error("external clock kept after reset");
	property p_mon;
		cmd_wr && reg_wdata == CMD_SELF_OFFSET_CAL && converting && !powered_down && quiet
			|=> (monitor_select == MON_SELF_OFFSET)[*8];
	endproperty
	a_mon: assert property (p_mon)
		else $error("monitor not forced in self cal");
	property p_pd;
		powered_down && quiet && !(cmd_wr && reg_wdata == CMD_RESUME) |=> powered_down;
	endproperty
	a_pd: assert property (p_pd)
		else $error("left power-down without resume");
	property p_stby;
		cal_wr && !converting && !powered_down && quiet |=> !converting;
	endproperty
	a_stby: assert property (p_stby)
		else $error("cal acted in standby");
	c_done: cover property ($fell(conversion_done_n));
	c_pd: cover property ($rose(powered_down));
	c_cal: cover property (converting && monitor_select == MON_SELF_OFFSET);
endmodule // adsc_core_asserts
bind adsc_core adsc_core_asserts u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reset_pin_n, .gpio_oe, .gpio_func, .conversion_done_n, .conv_data, .monitor_select,
	.ext_clk_select, .converting, .powered_down);
`default_nettype wire

// file: sim/adsc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module adsc_front_model
	import adsc_pkg::*;
(
	input wire logic [3:0] gpio_out,
	input wire logic [3:0] gpio_oe,
	input wire logic [3:0] ext_level,
	output logic [3:0] gpio_in,
	output logic [3:0] pin_level
);
	// ------
	// Pins
	// ------
	// Driven pins follow the core, others the external source
	assign pin_level = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
	assign gpio_in = pin_level;
endmodule // adsc_front_model
`default_nettype wire

// file: sim/test_adc_status_gpio_calibration.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_gpio_calibration
	import adsc_pkg::*;
;
	logic clk, lclk, rst_n, reg_wr, reg_rd, reset_pin_n, start_pin, ref_low_in;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [15:0] filter_data, conv_data;
	logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_func, ext_level, pins;
	logic conversion_done_n, ext_clk_select, converting, powered_down;
	logic [2:0] monitor_select;
	int errors, total_checks, tick, n;
	logic [15:0] ft[5] = '{16'h1234, 16'h1234, 16'h7000, 16'h8000, 16'h0000};
	logic [15:0] fo[5] = '{16'h0000, 16'h0010, 16'h0000, 16'h7fff, 16'hffff};
	logic [15:0] fg[5] = '{16'h4000, 16'h8000, 16'h8000, 16'h8000, 16'h4000};
	logic [15:0] fe[5] = '{16'h1234, 16'h2448, 16'h7fff, 16'h8000, 16'h0001};
	logic [7:0] cc[3] = '{CMD_SELF_OFFSET_CAL, CMD_SYS_OFFSET_CAL, CMD_SYS_GAIN_CAL};
	logic [15:0] cf[3] = '{16'h0003, 16'h0020, 16'h2020};
	logic [7:0] cs[3] = '{8'h00, 8'h18, 8'h08};
	int ca[3] = '{1, 16, 4};
	logic [7:0] ra[3] = '{ADDR_OFC_LO, ADDR_OFC_LO, ADDR_FSC_LO};
	logic [15:0] ce[3] = '{16'h0003, 16'h0020, 16'hfffe};
	logic [15:0] cd[3] = '{16'h0000, 16'h0000, 16'h7fff};

	adsc_core uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reset_pin_n, .start_pin, .ref_low_in, .filter_data, .gpio_in, .gpio_out, .gpio_oe,
		.gpio_func, .conversion_done_n, .conv_data, .monitor_select, .ext_clk_select,
		.converting, .powered_down);
	adsc_front_model u_front (.gpio_out, .gpio_oe, .ext_level, .gpio_in, .pin_level(pins));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		forever #80 lclk = ~lclk;
	end
	// ------
	// Tasks
	// ------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == 40000) begin
			errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(16'(reg_rdata), 16'(exp));
	endtask
	// Counts cycles until done falls; a hang ends at the bound
	task automatic wait_done(output int k);
		k = 0;
		#1;
		while (conversion_done_n !== 1'b0 && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 3000) begin
			errors++;
			$display("mismatch at %0t: done never fell", $time);
		end
	endtask
	// ------
	// Tests
	// ------
	initial begin
		{rst_n, reg_wr, reg_rd, start_pin, ref_low_in, tick, errors, total_checks} = '0;
		{reg_addr, reg_wdata, filter_data} = '0;
		reset_pin_n = 1'b1;
		ext_level = 4'ha;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ADDR_STATUS, 8'hc0);
		repeat (20) @(posedge clk);
		rdc(ADDR_STATUS, 8'h80);
		wr(ADDR_STATUS, 8'h00);
		rdc(ADDR_STATUS, 8'h00);
		rdc(ADDR_DRATE, RST_DRATE);
		rdc(ADDR_FSC_HI, 8'h40);
		rdc(8'h3f, 8'h00);
		$display("test reset done");
		wr(ADDR_GPIO_CFG, 8'h0f);
		wr(ADDR_GPIO_VAL, 8'h35);
		#1 chk(16'(gpio_oe), 16'h000c);
		chk(16'(pins), 16'h0006);
		repeat (3) @(posedge clk);
		rdc(ADDR_GPIO_VAL, 8'h36);
		wr(ADDR_GPIO_CFG, 8'h03);
		#1 chk(16'(gpio_oe), 16'h0000);
		chk(16'(gpio_func), 16'h0003);
		$display("test gpio done");
		wr(ADDR_DRATE, 8'h34);
		for (int i = 0; i < 5; i++) begin
			filter_data <= ft[i];
			wr(ADDR_OFC_LO, fo[i][7:0]);
			wr(ADDR_OFC_HI, fo[i][15:8]);
			wr(ADDR_FSC_LO, fg[i][7:0]);
			wr(ADDR_FSC_HI, fg[i][15:8]);
			wr(ADDR_CMD, CMD_START);
			wait_done(n);
			chk(conv_data, fe[i]);
			chk(16'(converting), 16'h0000);
		end
		$display("test datapath done");
		ref_low_in <= 1'b1;
		wr(ADDR_CMD, CMD_START);
		wait_done(n);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_REFCTL, 8'h80);
		wr(ADDR_CMD, CMD_START);
		wait_done(n);
		rdc(ADDR_STATUS, 8'h01);
		ref_low_in <= 1'b0;
		wr(ADDR_CMD, CMD_START);
		rdc(ADDR_STATUS, 8'h01);
		wait_done(n);
		rdc(ADDR_STATUS, 8'h00);
		wr(ADDR_CMD, CMD_SELF_OFFSET_CAL);
		@(posedge clk);
		#1 chk(16'(converting), 16'h0000);
		$display("test monitor done");
		for (int i = 0; i < 3; i++) begin
			filter_data <= cf[i];
			wr(ADDR_SYSCTL, cs[i]);
			wr(ADDR_CMD, CMD_START);
			wr(ADDR_CMD, cc[i]);
			n = 0;
			while (converting === 1'b1 && n < 3000) begin
				@(posedge clk);
				n++;
			end
			chk(16'(n > ca[i] * 64 + 56 && n < ca[i] * 64 + 200), 16'h0001);
			chk(conv_data, cd[i]);
			rdc(ra[i], ce[i][7:0]);
			rdc(ra[i] + 8'h01, ce[i][15:8]);
		end
		$display("test calibration done");
		wr(ADDR_CMD, CMD_START);
		wr(ADDR_CMD, CMD_SLEEP);
		#1 chk(16'({powered_down, converting}), 16'h0002);
		wr(ADDR_DRATE, 8'h00);
		rdc(ADDR_DRATE, 8'h34);
		wr(ADDR_CMD, CMD_START);
		#1 chk(16'(converting), 16'h0000);
		wr(ADDR_CMD, CMD_RESUME);
		#1 chk(16'({powered_down, converting}), 16'h0000);
		$display("test power done");
		@(posedge lclk);
		@(posedge clk);
		start_pin <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(16'(converting), 16'h0001);
		repeat (30) @(posedge clk);
		wr(ADDR_CMD, CMD_START);
		wait_done(n);
		chk(16'(n >= 60 && n <= 70), 16'h0001);
		start_pin <= 1'b0;
		$display("test restart done");
		wr(ADDR_DRATE, 8'h74);
		#1 chk(16'(ext_clk_select), 16'h0001);
		wr(ADDR_CMD, CMD_RESET);
		repeat (3) @(posedge clk);
		#1 chk(16'(ext_clk_select), 16'h0000);
		rdc(ADDR_DRATE, RST_DRATE);
		rdc(ADDR_STATUS, 8'h40);
		wr(ADDR_OFC_LO, 8'h55);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(ADDR_OFC_LO, 8'h00);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ADDR_STATUS, 8'hc0);
		$display("test resets done");
		finish_test();
	end
endmodule // test_adc_status_gpio_calibration
`default_nettype wire
